// ==== rtl/ips_interrupt_priority_status.sv ====
// Interrupt priority and status block: priorities for DMA channel 4 and the
// parallel port, forwarding of the winning request, and its status.
// Assumes a single AHB-Lite master whose hready is this slave's hreadyout.
module ips_interrupt_priority_status #(
   parameter logic [6:0] DMA4_VEC_INDEX = 7'h10, // Arbitrary placement in vector table
   parameter logic [6:0] PMP_VEC_INDEX  = 7'h20  // Arbitrary placement in vector table
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [31:0] haddr,
   input  wire logic        hsel,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        dmaXferDone,
   input  wire logic        pmpEvent,
   output logic             irq,
   output logic             cpuIrqReq,
   output logic      [3:0]  cpuLevel,
   output logic      [6:0]  cpuVector
);

   ips_pkg::ips_bus_state_t state_reg;
   ips_pkg::ips_bus_state_t state_next;
   logic [7:0]  addr_reg;
   logic        accept;
   logic        wrEn;
   logic [2:0]  dmaPrio_reg;
   logic [2:0]  pmpPrio_reg;
   logic [1:0]  stat_reg;
   logic [1:0]  stat_next;
   logic [1:0]  mask_reg;
   logic        dmaHalf_reg;
   logic [15:0] dmaLen_reg;
   logic        dmaEvent;
   logic [31:0] rdMux;
   logic        dmaReq;
   logic        pmpReq;
   logic        dmaWins;

   // Address phase is taken only when the bus is ready
   assign accept    = hsel && htrans[1] && hready;
   assign wrEn      = (state_reg == ips_pkg::IPS_BUS_WRITE);
   // One wait state on reads so read data comes from a flop
   assign hreadyout = (state_reg != ips_pkg::IPS_BUS_RDWAIT);
   assign hresp     = 1'b0;

   // Next bus phase
   always_comb begin
      state_next = ips_pkg::IPS_BUS_IDLE;
      unique case (state_reg)
         ips_pkg::IPS_BUS_RDWAIT: begin
            state_next = ips_pkg::IPS_BUS_RDDATA;
         end
         ips_pkg::IPS_BUS_IDLE,
         ips_pkg::IPS_BUS_WRITE,
         ips_pkg::IPS_BUS_RDDATA: begin
            if (accept) begin
               state_next = hwrite ? ips_pkg::IPS_BUS_WRITE : ips_pkg::IPS_BUS_RDWAIT;
            end
         end
      endcase
   end

   // Bus phase and captured address
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ips_pkg::IPS_BUS_IDLE;
         addr_reg  <= 8'h00;
      end else begin
         state_reg <= state_next;
         if (accept) begin
            addr_reg <= {haddr[7:2], 2'b00};
         end
      end
   end

   // Priority fields; bits outside them are simply not stored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dmaPrio_reg <= ips_pkg::PRIO_RESET;
         pmpPrio_reg <= ips_pkg::PRIO_RESET;
      end else if (wrEn && addr_reg == ips_pkg::ADDR_PRIO) begin
         dmaPrio_reg <= ips_pkg::ipsPrioOf(hwdata, ips_pkg::DMA4_PRIO_LSB);
         pmpPrio_reg <= ips_pkg::ipsPrioOf(hwdata, ips_pkg::PMP_PRIO_LSB);
      end
   end

   // Interrupt mask and DMA channel configuration
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_reg    <= ips_pkg::IRQ_MASK_RESET;
         dmaHalf_reg <= 1'b0;
         dmaLen_reg  <= ips_pkg::BLK_RESET;
      end else if (wrEn) begin
         if (addr_reg == ips_pkg::ADDR_IRQ_MASK) begin
            mask_reg <= hwdata[1:0];
         end
         if (addr_reg == ips_pkg::ADDR_DMA_CTRL) begin
            dmaHalf_reg <= hwdata[ips_pkg::DMA_HALF_BIT];
            dmaLen_reg  <= hwdata[15:0];
         end
      end
   end

   // Channel 4 block progress
   ips_dma_event uDmaEvent (
      .clk        (clk),
      .rst_n      (rst_n),
      .xferDone   (dmaXferDone),
      .halfMode   (dmaHalf_reg),
      .blockLen   (dmaLen_reg),
      .blockEvent (dmaEvent)
   );

   // Sticky pending flags; a new event beats a write-one clear in the same cycle
   always_comb begin
      stat_next = stat_reg;
      if (wrEn && addr_reg == ips_pkg::ADDR_IRQ_STAT) begin
         stat_next = stat_reg & ~hwdata[1:0];
      end
      stat_next[ips_pkg::IRQ_DMA4] = stat_next[ips_pkg::IRQ_DMA4] | dmaEvent;
      stat_next[ips_pkg::IRQ_PMP]  = stat_next[ips_pkg::IRQ_PMP] | pmpEvent;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_reg <= 2'h0;
      end else begin
         stat_reg <= stat_next;
      end
   end

   // Summary interrupt, regardless of priority
   assign irq = |(stat_reg & mask_reg);

   // A zero priority takes a source out of arbitration entirely
   assign dmaReq  = stat_reg[ips_pkg::IRQ_DMA4] && mask_reg[ips_pkg::IRQ_DMA4] && dmaPrio_reg != ips_pkg::PRIO_OFF;
   assign pmpReq  = stat_reg[ips_pkg::IRQ_PMP] && mask_reg[ips_pkg::IRQ_PMP] && pmpPrio_reg != ips_pkg::PRIO_OFF;
   // Ties go to the DMA channel, which sits lower in the natural order
   assign dmaWins = dmaReq && (!pmpReq || dmaPrio_reg >= pmpPrio_reg);

   // Forwarded request with its level and vector index
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpuIrqReq <= 1'b0;
         cpuLevel  <= 4'h0;
         cpuVector <= 7'h00;
      end else if (dmaWins) begin
         cpuIrqReq <= 1'b1;
         cpuLevel  <= {1'b0, dmaPrio_reg};
         cpuVector <= DMA4_VEC_INDEX;
      end else if (pmpReq) begin
         cpuIrqReq <= 1'b1;
         cpuLevel  <= {1'b0, pmpPrio_reg};
         cpuVector <= PMP_VEC_INDEX;
      end else begin
         cpuIrqReq <= 1'b0;
         cpuLevel  <= 4'h0;
         cpuVector <= 7'h00;
      end
   end

   // Read decode; unmapped words read zero
   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (addr_reg)
         ips_pkg::ADDR_PRIO: begin
            rdMux[ips_pkg::DMA4_PRIO_LSB +: ips_pkg::PRIO_W] = dmaPrio_reg;
            rdMux[ips_pkg::PMP_PRIO_LSB +: ips_pkg::PRIO_W]  = pmpPrio_reg;
         end
         ips_pkg::ADDR_STATUS: begin
            rdMux[ips_pkg::LEVEL_LSB +: ips_pkg::LEVEL_W] = cpuLevel;
            rdMux[ips_pkg::VEC_LSB +: ips_pkg::VEC_W]     = cpuVector;
         end
         ips_pkg::ADDR_IRQ_STAT: begin
            rdMux[1:0] = stat_reg;
         end
         ips_pkg::ADDR_IRQ_MASK: begin
            rdMux[1:0] = mask_reg;
         end
         ips_pkg::ADDR_DMA_CTRL: begin
            rdMux[ips_pkg::DMA_HALF_BIT] = dmaHalf_reg;
            rdMux[15:0]                  = dmaLen_reg;
         end
         default: begin
            rdMux = 32'h0000_0000;
         end
      endcase
   end

   // Read data is loaded during the wait state and held until the next read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (state_reg == ips_pkg::IPS_BUS_RDWAIT) begin
         hrdata <= rdMux;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_bothPending;
      dmaReq && pmpReq;
   endsequence

   sequence s_readPhase;
      accept && !hwrite ##1 !hreadyout;
   endsequence

   property p_prioOff;
      (dmaPrio_reg == 3'h0 && pmpPrio_reg == 3'h0) |=> !cpuIrqReq;
   endproperty
   a_prioOff: assert property (p_prioOff) else $error("request forwarded with all priorities zero");

   property p_levelFollows;
      (dmaWins && !$past(dmaWins)) |=> (cpuLevel == {1'b0, $past(dmaPrio_reg)}) && cpuIrqReq;
   endproperty
   a_levelFollows: assert property (p_levelFollows) else $error("level does not match DMA priority");

   property p_levelIdle;
      !cpuIrqReq |-> cpuLevel == 4'h0;
   endproperty
   a_levelIdle: assert property (p_levelIdle) else $error("level nonzero with no request");

   property p_vectorKnown;
      cpuIrqReq |-> (cpuVector == DMA4_VEC_INDEX || cpuVector == PMP_VEC_INDEX);
   endproperty
   a_vectorKnown: assert property (p_vectorKnown) else $error("vector index of no source");

   // The event itself must land; software may legally clear it one cycle later
   property p_dmaSticky;
      dmaEvent |=> stat_reg[ips_pkg::IRQ_DMA4];
   endproperty
   a_dmaSticky: assert property (p_dmaSticky) else $error("DMA event lost");

   property p_unusedZero;
      (state_reg == ips_pkg::IPS_BUS_RDDATA && addr_reg == ips_pkg::ADDR_PRIO)
         |-> (hrdata & ~ips_pkg::PRIO_MASK) == 32'h0000_0000;
   endproperty
   a_unusedZero: assert property (p_unusedZero) else $error("unimplemented priority bit reads one");

   property p_statusZero;
      (state_reg == ips_pkg::IPS_BUS_RDDATA && addr_reg == ips_pkg::ADDR_STATUS)
         |-> (hrdata & ~ips_pkg::STATUS_MASK) == 32'h0000_0000;
   endproperty
   a_statusZero: assert property (p_statusZero) else $error("unimplemented status bit reads one");

   property p_highestWins;
      s_bothPending ##0 (pmpPrio_reg > dmaPrio_reg) |=> cpuVector == PMP_VEC_INDEX;
   endproperty
   a_highestWins: assert property (p_highestWins) else $error("lower priority source forwarded");

   property p_readWait;
      s_readPhase |=> hreadyout && state_reg == ips_pkg::IPS_BUS_RDDATA;
   endproperty
   a_readWait: assert property (p_readWait) else $error("read wait state wrong length");

endmodule

// ==== rtl/ips_pkg.sv ====
// Shared constants for the interrupt priority and status block.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package ips_pkg;

   // Register byte offsets
   localparam logic [7:0]  ADDR_PRIO      = 8'h00;
   localparam logic [7:0]  ADDR_STATUS    = 8'h04;
   localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h08;
   localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h0C;
   localparam logic [7:0]  ADDR_DMA_CTRL  = 8'h10;

   // Field widths
   localparam int          PRIO_W         = 3;
   localparam int          LEVEL_W        = 4;
   localparam int          VEC_W          = 7;
   localparam int          BLK_W          = 16;
   localparam int          IRQ_W          = 2;

   // Field positions
   localparam int          DMA4_PRIO_LSB  = 8;
   localparam int          PMP_PRIO_LSB   = 4;
   localparam int          LEVEL_LSB      = 8;
   localparam int          VEC_LSB        = 0;
   localparam int          DMA_HALF_BIT   = 16;
   localparam int          IRQ_DMA4       = 0;
   localparam int          IRQ_PMP        = 1;

   // Implemented bits, everything else reads zero
   localparam logic [31:0] PRIO_MASK      = 32'h0000_0770;
   localparam logic [31:0] STATUS_MASK    = 32'h0000_0F7F;

   // Reset values, and the priority code that takes a source out of arbitration
   localparam logic [2:0]  PRIO_RESET     = 3'h4;
   localparam logic [15:0] BLK_RESET      = 16'h0001;
   localparam logic [1:0]  IRQ_MASK_RESET = 2'h0;
   localparam logic [2:0]  PRIO_OFF       = 3'h0;

   // Bus phase tracking
   typedef enum logic [1:0] {
      IPS_BUS_IDLE   = 2'b00,
      IPS_BUS_WRITE  = 2'b01,
      IPS_BUS_RDWAIT = 2'b10,
      IPS_BUS_RDDATA = 2'b11
   } ips_bus_state_t;

   // Pull a priority field out of a bus word
   function automatic logic [2:0] ipsPrioOf(input logic [31:0] word, input int lsb);
      ipsPrioOf = word[lsb +: 3];
   endfunction

endpackage

// ==== rtl/ips_dma_event.sv ====
// DMA channel block-progress event generator.
// Assumes xferDone pulses once per element moved by the channel.
module ips_dma_event (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        xferDone,
   input  wire logic        halfMode,
   input  wire logic [15:0] blockLen,
   output logic             blockEvent
);

   logic [15:0] count_reg;
   logic [15:0] countInc;
   logic [15:0] halfPoint;
   logic        lastXfer;
   logic        hitPoint;

   // A zero length acts as one, so a block always ends
   assign countInc  = count_reg + 16'h0001;
   assign halfPoint = {1'b0, blockLen[15:1]};
   assign lastXfer  = (countInc >= blockLen);
   // Half point of a one-element block is empty; fall back to the full mark
   assign hitPoint  = (halfMode && halfPoint != 16'h0000) ? (countInc == halfPoint) : lastXfer;

   // Element counter within the current block
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 16'h0000;
      end else if (xferDone) begin
         count_reg <= lastXfer ? 16'h0000 : countInc;
      end
   end

   // One-cycle event pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         blockEvent <= 1'b0;
      end else begin
         blockEvent <= xferDone && hitPoint;
      end
   end

endmodule

// ==== verif/ips_cpu_model.sv ====
// Behavioural processor core taking forwarded interrupt requests.
// Assumes request, level and vector are registered on the same clock.
module ips_cpu_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       cpuIrqReq,
   input  wire logic [3:0] cpuLevel,
   input  wire logic [6:0] cpuVector,
   output logic      [3:0] takenLevel,
   output logic      [6:0] takenVector
);
   timeunit 1ns;
   timeprecision 1ps;
   // Latch what the core would vector to; zero so stale values never pass
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         takenLevel  <= 4'h0;
         takenVector <= 7'h0;
      end else begin
         takenLevel  <= cpuIrqReq ? cpuLevel : 4'h0;
         takenVector <= cpuIrqReq ? cpuVector : 7'h0;
      end
   end
endmodule

// ==== verif/tb_interrupt_priority_status.sv ====
// Self-checking bench for the interrupt priority and status block.
// Assumes one AHB-Lite master and a core model on the request outputs.
module tb_interrupt_priority_status;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] VD = 7'h15; // Arbitrary vector placement
   localparam logic [6:0] VP = 7'h2A; // Arbitrary vector placement
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        dmaXferDone = 1'b0;
   logic        pmpEvent = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rdVal;
   logic        hreadyout;
   logic        hresp;
   logic        irq;
   logic        cpuIrqReq;
   logic [3:0]  cpuLevel;
   logic [3:0]  takenLevel;
   logic [6:0]  cpuVector;
   logic [6:0]  takenVector;
   int          failures = 0;
   int          nCompared = 0;

   // Free-running system clock
   always #12.5 clk = ~clk;

   ips_interrupt_priority_status #(.DMA4_VEC_INDEX(VD), .PMP_VEC_INDEX(VP)) dut_u (
      .clk(clk), .rst_n(rst_n), .haddr(haddr), .hsel(hsel), .htrans(htrans),
      .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .dmaXferDone(dmaXferDone), .pmpEvent(pmpEvent),
      .irq(irq), .cpuIrqReq(cpuIrqReq), .cpuLevel(cpuLevel), .cpuVector(cpuVector));

   ips_cpu_model cpu_u (
      .clk(clk), .rst_n(rst_n), .cpuIrqReq(cpuIrqReq), .cpuLevel(cpuLevel),
      .cpuVector(cpuVector), .takenLevel(takenLevel), .takenVector(takenVector));

   // One single transfer, called just after a rising edge; ready and read data
   // are taken at the rising edge itself, before the design updates them
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsel   <= 1'b1;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rdVal = hrdata;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      nCompared++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      chk(what, exp, rdVal);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   // Single-cycle event pulses, then time for the status to settle
   task automatic pulse(input logic dma, input int n);
      repeat (n) begin
         @(posedge clk);
         dmaXferDone <= dma;
         pmpEvent    <= !dma;
         @(posedge clk);
         dmaXferDone <= 1'b0;
         pmpEvent    <= 1'b0;
      end
      repeat (3) @(posedge clk);
   endtask

   // Forwarded request seen by the core and mirrored in the status word
   task automatic cpuChk(input logic [3:0] lv, input logic [6:0] vc);
      repeat (4) @(posedge clk);
      chk("request", {31'h0, lv != 4'h0}, {31'h0, cpuIrqReq});
      chk("level", {28'h0, lv}, {28'h0, takenLevel});
      chk("vector", {25'h0, vc}, {25'h0, takenVector});
      rd(ips_pkg::ADDR_STATUS, {20'h0, lv, 1'b0, vc}, "status");
   endtask

   task automatic prio(input logic [31:0] w, input logic [3:0] lv, input logic [6:0] vc);
      bus(1'b1, ips_pkg::ADDR_PRIO, w);
      cpuChk(lv, vc);
   endtask

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", nCompared, failures);
      if (failures == 0 && nCompared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Whole run is a few hundred cycles; this is ample margin
   initial begin
      #200us;
      failures++;
      wrap_up();
   end

   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(ips_pkg::ADDR_PRIO, 32'h0000_0440, "prio reset");
      rd(ips_pkg::ADDR_STATUS, 32'h0, "status reset");
      bus(1'b1, ips_pkg::ADDR_PRIO, 32'hFFFF_FFFF);
      rd(ips_pkg::ADDR_PRIO, 32'h0000_0770, "prio spare bits");
      bus(1'b1, ips_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
      rd(ips_pkg::ADDR_STATUS, 32'h0, "status write");
      rd(8'h3C, 32'h0, "unmapped");
      $display("Test registers done");
      // Masked event sets status but raises nothing
      pulse(1'b0, 1);
      rd(ips_pkg::ADDR_IRQ_STAT, 32'h2, "pmp status");
      chk("irq masked", 32'h0, {31'h0, irq});
      cpuChk(4'h0, 7'h0);
      bus(1'b1, ips_pkg::ADDR_IRQ_MASK, 32'h3);
      repeat (2) @(posedge clk);
      chk("irq on", 32'h1, {31'h0, irq});
      // Every priority code on the parallel port alone
      for (int p = 0; p < 8; p++) begin
         prio(32'(p) << 4, 4'(p), (p != 0) ? VP : 7'h0);
      end
      $display("Test priorities done");
      // Full block of four elements
      bus(1'b1, ips_pkg::ADDR_DMA_CTRL, 32'h0000_0004);
      pulse(1'b1, 3);
      rd(ips_pkg::ADDR_IRQ_STAT, 32'h2, "dma before end");
      pulse(1'b1, 1);
      rd(ips_pkg::ADDR_IRQ_STAT, 32'h3, "dma block end");
      // Arbitration between two pending sources, tie goes to the channel
      prio(32'h0000_0350, 4'h5, VP);
      prio(32'h0000_0650, 4'h6, VD);
      prio(32'h0000_0550, 4'h5, VD);
      prio(32'h0000_0050, 4'h5, VP);
      prio(32'h0000_0550, 4'h5, VD);
      bus(1'b1, ips_pkg::ADDR_IRQ_STAT, 32'h1);
      cpuChk(4'h5, VP);
      bus(1'b1, ips_pkg::ADDR_IRQ_STAT, 32'h2);
      rd(ips_pkg::ADDR_IRQ_STAT, 32'h0, "cleared");
      chk("irq off", 32'h0, {31'h0, irq});
      cpuChk(4'h0, 7'h0);
      $display("Test arbitration done");
      // Half mode on an eight element block
      bus(1'b1, ips_pkg::ADDR_DMA_CTRL, 32'h0001_0008);
      pulse(1'b1, 3);
      rd(ips_pkg::ADDR_IRQ_STAT, 32'h0, "half early");
      pulse(1'b1, 1);
      rd(ips_pkg::ADDR_IRQ_STAT, 32'h1, "half block");
      cpuChk(4'h5, VD);
      $display("Test half block done");
      wrap_up();
   end
endmodule
